// >>> dv/idle_powerdown_controller_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
`define WAITF(c) begin k = 0; while (!(c) && k < 64) begin \
    @(posedge i_clk); #1; k++; end if (k >= 64) begin errors++; \
    finish_test(); end end
module idle_powerdown_controller_tb;
    logic       i_clk = 1'b0;
    logic       i_rst_b = 1'b0;
    logic       i_rst_pin = 1'b0;
    logic       i_pwr_ctrl_we = 1'b0;
    logic [3:0] i_pwr_ctrl_wdata = 4'h0;
    logic       i_any_irq = 1'b0;
    logic [1:0] i_ext_irq_en = 2'h0;
    logic [1:0] start = 2'h0;
    logic [1:0] irq_n;
    logic [3:0] pwr_ctrl;
    logic       cpu_en, per_en, osc_en, ram_blk, hold, core_rst;
    int         errors = 0;
    int         n_checks = 0;
    int         k;
    always #2.5 i_clk = ~i_clk;
    idle_powerdown_controller #(.OSC_SETTLE(2), .RESET_DRAIN(2))
        i_idle_powerdown_controller (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_rst_pin(i_rst_pin), .i_pwr_ctrl_we(i_pwr_ctrl_we),
        .i_pwr_ctrl_wdata(i_pwr_ctrl_wdata), .i_any_irq_enabled(i_any_irq),
        .i_ext_irq_en(i_ext_irq_en), .i_ext_irq_zero_n(irq_n[0]),
        .i_ext_irq_one_n(irq_n[1]), .o_pwr_ctrl(pwr_ctrl),
        .o_cpu_clk_en(cpu_en),
        .o_periph_clk_en(per_en), .o_osc_en(osc_en), .o_ram_block(ram_blk),
        .o_cpu_hold(hold), .o_core_reset(core_rst));
    wake_source_model i_wake_source_model (.i_clk(i_clk), .i_start(start),
        .i_len(8'h0A), .o_irq_n(irq_n));
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] d);
        @(posedge i_clk);
        i_pwr_ctrl_we <= 1'b1;
        i_pwr_ctrl_wdata <= d;
        @(posedge i_clk);
        i_pwr_ctrl_we <= 1'b0;
        #1;
    endtask
    task automatic t_idle();
        wr(4'hD);
        `CHK({pwr_ctrl, cpu_en, per_en, osc_en}, 7'h6B)
        wr(4'h2);
        `CHK(pwr_ctrl, 4'hD)
        @(posedge i_clk);
        i_any_irq <= 1'b1;
        @(posedge i_clk);
        i_any_irq <= 1'b0;
        #1;
        `CHK({pwr_ctrl, cpu_en}, 5'h19)
        $display("idle wake test done");
    endtask
    task automatic t_down(input int n);
        @(posedge i_clk);
        i_ext_irq_en <= 2'h0;
        wr(4'hF);
        `CHK({pwr_ctrl, cpu_en, per_en, osc_en}, 7'h78)
        start[n] <= 1'b1;
        @(posedge i_clk);
        start[n] <= 1'b0;
        repeat (12) @(posedge i_clk);
        #1;
        `CHK(pwr_ctrl[1], 1'b1)
        @(posedge i_clk);
        i_ext_irq_en[n] <= 1'b1;
        start[n] <= 1'b1;
        @(posedge i_clk);
        start[n] <= 1'b0;
        `WAITF(!pwr_ctrl[1])
        `CHK({pwr_ctrl, cpu_en, per_en, osc_en, hold}, 8'hCF)
        `WAITF(!hold)
        `CHK(irq_n[n], 1'b1)
        $display("power-down wake test done");
    endtask
    task automatic t_rst(input logic [3:0] d);
        wr(d);
        @(posedge i_clk);
        i_rst_pin <= 1'b1;
        #1;
        `WAITF(pwr_ctrl[1:0] == 2'h0)
        `CHK({cpu_en, per_en, osc_en}, 3'h7)
        `WAITF(ram_blk)
        `WAITF(core_rst)
        `CHK(ram_blk, 1'b0)
        @(posedge i_clk);
        i_rst_pin <= 1'b0;
        #1;
        `WAITF(!core_rst)
        $display("reset wake test done");
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_idle();
        t_down(0);
        t_down(1);
        t_rst(4'h1);
        t_rst(4'h2);
        finish_test();
    end
endmodule // idle_powerdown_controller_tb
bind idle_powerdown_controller pwr_mode_monitor #(.OSC_SETTLE(OSC_SETTLE),
    .RESET_DRAIN(RESET_DRAIN)) i_pwr_mode_monitor (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_rst_pin(i_rst_pin),
    .i_pwr_ctrl_we(i_pwr_ctrl_we), .i_pwr_ctrl_wdata(i_pwr_ctrl_wdata),
    .i_any_irq_enabled(i_any_irq_enabled),
    .i_ext_irq_en(i_ext_irq_en), .i_ext_irq_zero_n(i_ext_irq_zero_n),
    .i_ext_irq_one_n(i_ext_irq_one_n), .o_pwr_ctrl(o_pwr_ctrl),
    .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en),
    .o_osc_en(o_osc_en), .o_ram_block(o_ram_block),
    .o_cpu_hold(o_cpu_hold), .o_core_reset(o_core_reset));

// >>> dv/pwr_mode_monitor.sv
`timescale 1ns/10ps
module pwr_mode_monitor #(
    parameter int OSC_SETTLE  = 16,
    parameter int RESET_DRAIN = 4
) (
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       i_rst_pin,
    input wire logic       i_pwr_ctrl_we,
    input wire logic [3:0] i_pwr_ctrl_wdata,
    input wire logic       i_any_irq_enabled,
    input wire logic [1:0] i_ext_irq_en,
    input wire logic       i_ext_irq_zero_n,
    input wire logic       i_ext_irq_one_n,
    input wire logic [3:0] o_pwr_ctrl,
    input wire logic       o_cpu_clk_en,
    input wire logic       o_periph_clk_en,
    input wire logic       o_osc_en,
    input wire logic       o_ram_block,
    input wire logic       o_cpu_hold,
    input wire logic       o_core_reset
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic run;
    int   hcnt;
    int   rcnt;
    assign run = o_cpu_clk_en && o_osc_en && !o_cpu_hold && !o_ram_block
                 && !o_core_reset && !i_rst_pin;
    // Run lengths of hold and RAM blocking, measured at their falling edge.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hcnt <= 0;
            rcnt <= 0;
        end else begin
            hcnt <= o_cpu_hold ? hcnt + 1 : 0;
            rcnt <= o_ram_block ? rcnt + 1 : 0;
        end
    end
    property p_idle_in;
        run && i_pwr_ctrl_we && i_pwr_ctrl_wdata[1:0] == 2'h1
            |=> !o_cpu_clk_en && o_periph_clk_en && o_osc_en
            && o_pwr_ctrl == $past(i_pwr_ctrl_wdata);
    endproperty
    a_idle_in: assert property (p_idle_in) else $error("idle entry");
    property p_down_in;
        run && i_pwr_ctrl_we && i_pwr_ctrl_wdata[1] |=> o_pwr_ctrl[1]
            && !o_osc_en && !o_periph_clk_en && !o_cpu_clk_en;
    endproperty
    a_down_in: assert property (p_down_in) else $error("down entry");
    property p_idle_wake;
        o_pwr_ctrl[1:0] == 2'h1 && i_any_irq_enabled && !i_rst_pin
            |=> o_pwr_ctrl[1:0] == 2'h0 && o_cpu_clk_en;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake");
    property p_down_stay;
        (o_pwr_ctrl[1] && !i_rst_pin && (i_ext_irq_zero_n || !i_ext_irq_en[0])
            && (i_ext_irq_one_n || !i_ext_irq_en[1]))[*3] |=> o_pwr_ctrl[1];
    endproperty
    a_down_stay: assert property (p_down_stay) else $error("down woke");
    property p_down_wake;
        (o_pwr_ctrl[1] && !i_ext_irq_zero_n && i_ext_irq_en[0])[*3]
            |-> ##[1:3] (!o_pwr_ctrl[1] && o_osc_en && o_periph_clk_en
            && o_cpu_clk_en);
    endproperty
    a_down_wake: assert property (p_down_wake) else $error("no wake");
    property p_hold_low;
        o_cpu_hold && !i_ext_irq_zero_n && i_ext_irq_en[0] |=> o_cpu_hold;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("hold early");
    property p_hold_settle;
        $fell(o_cpu_hold) |-> hcnt >= OSC_SETTLE;
    endproperty
    a_hold_settle: assert property (p_hold_settle) else $error("settle");
    property p_rst_clr;
        i_rst_pin[*4] |-> o_pwr_ctrl[1:0] == 2'h0 && o_cpu_clk_en && o_osc_en
            && o_periph_clk_en;
    endproperty
    a_rst_clr: assert property (p_rst_clr) else $error("reset clear");
    property p_drain;
        $fell(o_ram_block) |-> rcnt == RESET_DRAIN + 1;
    endproperty
    a_drain: assert property (p_drain) else $error("ram block length");
endmodule // pwr_mode_monitor

// >>> dv/wake_source_model.sv
`timescale 1ns/10ps
module wake_source_model (
    input  wire logic       i_clk,
    input  wire logic [1:0] i_start,
    input  wire logic [7:0] i_len,
    output logic      [1:0] o_irq_n
);
    logic [7:0] cnt [2] = '{8'h00, 8'h00};
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < 2; k++) begin
            if (i_start[k])
                cnt[k] <= i_len;
            else if (cnt[k] != 8'h00)
                cnt[k] <= cnt[k] - 8'h01;
        end
    end
    assign o_irq_n = {cnt[1] == 8'h00, cnt[0] == 8'h00};
endmodule // wake_source_model

// >>> logic/idle_powerdown_controller.sv
`timescale 1ns/10ps
`include "pwr_mode_defines.svh"
module idle_powerdown_controller #(
    parameter int OSC_SETTLE  = `OSC_SETTLE_CYCLES,
    parameter int RESET_DRAIN = `RESET_DRAIN_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_rst_pin,
    input  wire logic       i_pwr_ctrl_we,
    input  wire logic [3:0] i_pwr_ctrl_wdata,
    input  wire logic       i_any_irq_enabled,
    input  wire logic [1:0] i_ext_irq_en,
    input  wire logic       i_ext_irq_zero_n,
    input  wire logic       i_ext_irq_one_n,
    output logic [3:0]      o_pwr_ctrl,
    output logic            o_cpu_clk_en,
    output logic            o_periph_clk_en,
    output logic            o_osc_en,
    output logic            o_ram_block,
    output logic            o_cpu_hold,
    output logic            o_core_reset
);
    initial begin
        if (OSC_SETTLE < 1 || OSC_SETTLE > 65535) begin
            $error("OSC_SETTLE out of range");
        end
        if (RESET_DRAIN < 1 || RESET_DRAIN > 255) begin
            $error("RESET_DRAIN out of range");
        end
    end

    logic [1:0]  ext_n;
    logic [1:0]  rst_sync;
    pwr_mode_pkg::pwr_state_t state;
    pwr_mode_pkg::pwr_state_t next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        idle_bit;
    logic        down_bit;
    logic        next_idle_bit;
    logic        next_down_bit;
    logic [1:0]  gflags;
    logic [1:0]  next_gflags;
    logic        rst_seen;
    logic        next_rst_seen;
    pwr_mode_pkg::pwr_ctrl_t ctrl;
    pwr_mode_pkg::pwr_ctrl_t next_ctrl;
    logic        ext_wake;
    logic        ext_active;

    pin_sync #(
        .WIDTH(2)
    ) u_ext_sync (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async ({i_ext_irq_one_n, i_ext_irq_zero_n}),
        .o_sync  (ext_n)
    );

    // The reset pin is active high; its synchroniser idles low.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], i_rst_pin};
        end
    end

    always_comb begin
        ext_wake   = |(~ext_n & i_ext_irq_en);
        ext_active = |(~ext_n);
    end

    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_idle_bit = idle_bit;
        next_down_bit = down_bit;
        next_gflags   = gflags;
        next_rst_seen = 1'b0;
        if (i_pwr_ctrl_we && state == pwr_mode_pkg::ST_RUN) begin
            next_idle_bit = i_pwr_ctrl_wdata[`PWR_IDLE_BIT];
            next_down_bit = i_pwr_ctrl_wdata[`PWR_DOWN_BIT];
            next_gflags   = {i_pwr_ctrl_wdata[`PWR_FLAG1_BIT],
                             i_pwr_ctrl_wdata[`PWR_FLAG0_BIT]};
        end
        unique case (state)
            pwr_mode_pkg::ST_RUN: begin
                if (next_down_bit) begin
                    next_state = pwr_mode_pkg::ST_PDOWN;
                end else if (next_idle_bit) begin
                    next_state = pwr_mode_pkg::ST_IDLE;
                end
            end
            pwr_mode_pkg::ST_IDLE: begin
                if (i_any_irq_enabled) begin
                    next_idle_bit = 1'b0;
                    next_state    = pwr_mode_pkg::ST_RUN;
                end
            end
            pwr_mode_pkg::ST_PDOWN: begin
                if (ext_wake) begin
                    next_down_bit = 1'b0;
                    next_idle_bit = 1'b0;
                    next_cnt      = 16'(OSC_SETTLE);
                    next_state    = pwr_mode_pkg::ST_WAKEHOLD;
                end
            end
            pwr_mode_pkg::ST_WAKEHOLD: begin
                if (cnt != 16'h0000) begin
                    next_cnt = cnt - 16'h0001;
                end
                if (cnt == 16'h0000 && !ext_active) begin
                    next_state = pwr_mode_pkg::ST_RUN;
                end
            end
            pwr_mode_pkg::ST_RSTDRAIN: begin
                if (cnt != 16'h0000) begin
                    next_cnt = cnt - 16'h0001;
                end else begin
                    next_state = pwr_mode_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = pwr_mode_pkg::ST_RUN;
            end
        endcase
        if (rst_sync[1]) begin
            next_idle_bit = 1'b0;
            next_down_bit = 1'b0;
            next_gflags   = `PWR_FLAG_RESET;
            next_rst_seen = 1'b1;
            // Only the first synced cycle starts the drain; later ones
            // let the drain count run down.
            if (!rst_seen) begin
                next_cnt   = 16'(RESET_DRAIN);
                next_state = pwr_mode_pkg::ST_RSTDRAIN;
            end
        end
    end

    // Enables follow the bits; the synchronised reset pin clears the
    // bits in the next-state logic, so it takes effect on a clock edge.
    always_comb begin
        next_ctrl = '0;
        next_ctrl.cpu_clk_en    = !next_idle_bit && !next_down_bit;
        next_ctrl.osc_en        = !next_down_bit;
        next_ctrl.periph_clk_en = !next_down_bit;
        next_ctrl.ram_block     = next_state == pwr_mode_pkg::ST_RSTDRAIN;
        next_ctrl.cpu_hold      = next_state == pwr_mode_pkg::ST_WAKEHOLD;
        next_ctrl.core_reset    = rst_sync[1] && rst_seen
                                  && state != pwr_mode_pkg::ST_RSTDRAIN;
    end

    // Interrupt wake clears only the idle and down bits; the flag bits are kept.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state    <= pwr_mode_pkg::ST_RUN;
            cnt      <= 16'h0000;
            idle_bit <= 1'b0;
            down_bit <= 1'b0;
            gflags   <= `PWR_FLAG_RESET;
            rst_seen <= 1'b0;
            ctrl     <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1,
                          osc_en: 1'b1, default: 1'b0};
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            idle_bit <= next_idle_bit;
            down_bit <= next_down_bit;
            gflags   <= next_gflags;
            rst_seen <= next_rst_seen;
            ctrl     <= next_ctrl;
        end
    end

    // Resume point is kept by the frozen core itself.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pwr_ctrl      <= `PWR_CTRL_RESET;
            o_cpu_clk_en    <= 1'b1;
            o_periph_clk_en <= 1'b1;
            o_osc_en        <= 1'b1;
            o_ram_block     <= 1'b0;
            o_cpu_hold      <= 1'b0;
            o_core_reset    <= 1'b0;
        end else begin
            o_pwr_ctrl      <= {next_gflags, next_down_bit, next_idle_bit};
            o_cpu_clk_en    <= next_ctrl.cpu_clk_en;
            o_periph_clk_en <= next_ctrl.periph_clk_en;
            o_osc_en        <= next_ctrl.osc_en;
            o_ram_block     <= next_ctrl.ram_block;
            o_cpu_hold      <= next_ctrl.cpu_hold;
            o_core_reset    <= next_ctrl.core_reset;
        end
    end
endmodule // idle_powerdown_controller

// >>> logic/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage_a;
    logic [WIDTH-1:0] next_stage_a;
    logic [WIDTH-1:0] next_sync;
    always_comb begin
        next_stage_a = i_async;
        next_sync    = stage_a;
    end
    // Pins idle high, so the chain resets to all ones.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stage_a <= '1;
            o_sync  <= '1;
        end else begin
            stage_a <= next_stage_a;
            o_sync  <= next_sync;
        end
    end
endmodule // pin_sync

// >>> logic/pwr_mode_defines.svh
// Operation
// - Idle freezes CPU clock, peripherals keep running.
// - Idle entered by instruction setting idle bit.
// - Both bits set selects power-down mode.
// - Enabled interrupt clears idle, resumes CPU.
// - Return continues after the idle instruction.
// - Reset pin clears idle bit asynchronously; the code clears it on a clock edge after the two-stage synchroniser.
// - Reset wake runs briefly, then vectors zero.
// - Block RAM, allow ports before reset takes over.
// - Power-down stops oscillator, freezes all clocks.
// - Power-down entered by instruction setting bit.
// - Only enabled external interrupts wake power-down.
// - Interrupt wake clears bit, restarts oscillator.
// - Execution held until external input released.
// - Interrupt wake leaves registers and RAM intact.
// - Reset pin clears power-down bit asynchronously; the code clears it on a clock edge after the two-stage synchroniser.
// - Reset wake reinitializes registers, keeps RAM.
`ifndef PWR_MODE_DEFINES_SVH
`define PWR_MODE_DEFINES_SVH
`define PWR_IDLE_BIT       0
`define PWR_DOWN_BIT       1
`define PWR_FLAG0_BIT      2
`define PWR_FLAG1_BIT      3
`define PWR_CTRL_RESET     4'h0
`define PWR_FLAG_RESET     2'h0
`define OSC_SETTLE_CYCLES  16
`define RESET_DRAIN_CYCLES 4
`endif

// >>> logic/pwr_mode_pkg.sv
package pwr_mode_pkg;
    typedef enum logic [4:0] {
        ST_RUN      = 5'h01,
        ST_IDLE     = 5'h02,
        ST_PDOWN    = 5'h04,
        ST_WAKEHOLD = 5'h08,
        ST_RSTDRAIN = 5'h10
    } pwr_state_t;
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_en;
        logic ram_block;
        logic cpu_hold;
        logic core_reset;
    } pwr_ctrl_t;
endpackage
